// File: inc/rxack_map.svh
// register offsets, field positions, frame codes, lengths and the delay reset value
// assumes: included by the design file and the bench only
`ifndef RXACK_MAP_SVH
`define RXACK_MAP_SVH

`define RXACK_OFF_CTRL      12'h000
`define RXACK_OFF_FILTER    12'h004
`define RXACK_OFF_DELAY     12'h008
`define RXACK_OFF_TXLEN     12'h00c
`define RXACK_OFF_PENDING   12'h010
`define RXACK_OFF_STATUS    12'h014
`define RXACK_OFF_PHYTX     12'h018

`define RXACK_CTRL_AUTO     0
`define RXACK_CTRL_RATE     1
`define RXACK_CTRL_CSUM     2
`define RXACK_CTRL_SRC      3
`define RXACK_CTRL_T2R      4
`define RXACK_FILT_PROM     4

`define RXACK_ST_FS         0
`define RXACK_ST_AM         1
`define RXACK_ST_EM         2
`define RXACK_ST_RXFE       3
`define RXACK_ST_IRQ_TX_FRAME_END       4
`define RXACK_ST_MATCH      5
`define RXACK_ST_EXT        6

`define RXACK_FT_DATA       3'h1
`define RXACK_FT_CMD        3'h3
`define RXACK_FT_ACK        3'h2
`define RXACK_LEN_CRC16     11'h005
`define RXACK_LEN_CRC32     11'h007
`define RXACK_PHY_OFDM      2'h1
`define RXACK_PHY_FSK       2'h0
`define RXACK_PHY_LEGACY    2'h2
`define RXACK_DELAY_RESET   16'h0000

`endif

// File: inc/rxack_pkg.sv
// types shared by the receive event and auto-ack block
// assumes: the map header supplies all numbers
package rxack_pkg;

	// header facts from the parser, valid with hdr_done
	typedef struct packed
	{
		logic [2:0] frame_type;
		logic       ack_request;
		logic [7:0] seq_num;
		logic       match_found_flag;
		logic       ext_match_found_flag;
		logic [3:0] unit_match;
	} rxack_hdr_t;

	// phy fields of the received frame
	typedef struct packed
	{
		logic [1:0] phy_kind;
		logic [2:0] modulation_coding_level;
		logic       sync_delimiter_choice;
		logic       legacy_phy_flag;
		logic       rate_mode_select;
		logic       ppdu_kind;
		logic       checksum_type_setting;
	} rxack_phy_t;

	// acknowledgement frame request to the transmitter
	typedef struct packed
	{
		logic [10:0] length;
		logic [7:0]  seq_num;
		logic        frame_pending;
		logic        from_buffer;
		rxack_phy_t  phy;
	} rxack_tx_t;

	typedef enum logic [1:0]
	{
		RXACK_IDLE,
		RXACK_WAIT,
		RXACK_SEND
	} rxack_state_t;

endpackage

// File: hdl/rxack_core.sv
// receive frame events and automatic acknowledgement engine
// assumes: an apb master on pclk; a header parser and a transmitter
// on the same clock that pulse their strobes for one cycle
//
// Notes on behaviour
// - frame start on every valid header
// - address match needs filter enabled
// - extended match needs filter enabled
// - frame end once frame is stored
// - no frame end if any filter fails
// - filter off: frame end follows first level
// - filter on: need match, extended, promiscuous or ack frame
// - ack frame: frame end, no matches
// - ack only for data/command requesting ack
// - procedure starts and waits only while enabled
// - send ack after programmed delay
// - rate adapt overrides then restores phy settings
// - copy received phy fields into transmit
// - checksum adapt only for fsk, legacy
// - internal ack copies sequence, fixed length
// - pending bit from matching filter unit
// - transmit frame end after ack sent
// - no ack: end in prepare state
// - match status updated after header parsed
// - filter enabled if any unit enabled
//
// Chosen here: the APB interface to the registers and the address map.
`include "rxack_map.svh"

module rxack_core
	import rxack_pkg::*;
#(
	parameter int DELAY_W = 16
)
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output wire logic        pready,
	output wire logic        pslverr,
	input  wire logic        hdr_valid,
	input  wire logic        hdr_done,
	input  wire rxack_hdr_t  hdr,
	input  wire logic        first_level_pass,
	input  wire logic        frame_stored,
	input  wire rxack_phy_t  rx_phy,
	input  wire logic        tx_done,
	output rxack_tx_t        ack_tx,
	output logic             ack_start,
	output logic             transmit_prepare_state,
	output logic [4:0]       irq_pulse
);

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	logic [4:0]         ctrl;
	logic [4:0]         filter;
	logic [DELAY_W-1:0] ack_delay;
	logic [10:0]        tx_len;
	logic [3:0]         ack_pending_bits;
	logic [6:0]         status;
	rxack_phy_t         phy_cfg;

	wire wr = psel & penable & pwrite;
	wire rd_hit_ctrl = paddr == `RXACK_OFF_CTRL;
	wire rd_hit_filt = paddr == `RXACK_OFF_FILTER;
	wire rd_hit_dly  = paddr == `RXACK_OFF_DELAY;
	wire rd_hit_len  = paddr == `RXACK_OFF_TXLEN;
	wire rd_hit_pend = paddr == `RXACK_OFF_PENDING;
	wire rd_hit_stat = paddr == `RXACK_OFF_STATUS;
	wire rd_hit_phy  = paddr == `RXACK_OFF_PHYTX;
	wire hit = rd_hit_ctrl | rd_hit_filt | rd_hit_dly | rd_hit_len
		| rd_hit_pend | rd_hit_stat | rd_hit_phy;
	assign pready  = 1'b1;
	assign pslverr = psel & penable & ~hit;

	wire auto_ack_enable           = ctrl[`RXACK_CTRL_AUTO];
	wire ack_rate_adapt_enable     = ctrl[`RXACK_CTRL_RATE];
	wire ack_checksum_adapt_enable = ctrl[`RXACK_CTRL_CSUM];
	wire ack_content_source        = ctrl[`RXACK_CTRL_SRC];
	wire [3:0] filter_unit_enable  = filter[3:0];
	wire promiscuous_accept        = filter[`RXACK_FILT_PROM];

	// ------------------------------------------------------------
	// receive event decision
	// ------------------------------------------------------------
	wire filt_on = |filter_unit_enable;
	wire is_ack  = hdr.frame_type == `RXACK_FT_ACK;
	wire ev_fs   = hdr_valid;
	wire ev_am   = hdr_done & filt_on & hdr.match_found_flag
		& ~is_ack;
	wire ev_em   = hdr_done & filt_on & hdr.ext_match_found_flag
		& ~is_ack;
	logic am_lat;
	logic em_lat;
	logic ackf_lat;
	wire pass_on  = first_level_pass
		& (am_lat | em_lat | promiscuous_accept | ackf_lat);
	wire pass = filt_on ? pass_on : first_level_pass;
	wire ev_fe = frame_stored & pass;

	// ------------------------------------------------------------
	// acknowledgement sequencer
	// ------------------------------------------------------------
	rxack_state_t       state;
	logic [DELAY_W-1:0] cnt;
	logic [7:0]         seq_lat;
	logic               need_ack;
	logic               pend_lat;
	rxack_phy_t         rx_phy_lat;

	wire ack_req = hdr_done & auto_ack_enable & hdr.ack_request
		& (|(hdr.unit_match & filter_unit_enable))
		& (hdr.frame_type == `RXACK_FT_DATA
		| hdr.frame_type == `RXACK_FT_CMD);
	wire [3:0] pend_sel = hdr.unit_match & ack_pending_bits;
	wire ev_te = tx_done & state == RXACK_SEND;

	// rate adaptation overlays the received fields only for the ack
	rxack_phy_t phy_adapt;
	always_comb
	begin
		phy_adapt = phy_cfg;
		if (ack_rate_adapt_enable)
		begin
			if (rx_phy_lat.phy_kind == `RXACK_PHY_OFDM)
				phy_adapt.modulation_coding_level =
					rx_phy_lat.modulation_coding_level;
			else if (rx_phy_lat.phy_kind == `RXACK_PHY_FSK)
				phy_adapt.sync_delimiter_choice =
					rx_phy_lat.sync_delimiter_choice;
			else
			begin
				phy_adapt.legacy_phy_flag = rx_phy_lat.legacy_phy_flag;
				phy_adapt.rate_mode_select = rx_phy_lat.rate_mode_select;
				phy_adapt.ppdu_kind = rx_phy_lat.ppdu_kind;
			end
		end
		if (ack_checksum_adapt_enable
			&& (rx_phy_lat.phy_kind == `RXACK_PHY_FSK
			|| (rx_phy_lat.phy_kind == `RXACK_PHY_LEGACY
			&& rx_phy_lat.legacy_phy_flag)))
			phy_adapt.checksum_type_setting =
				rx_phy_lat.checksum_type_setting;
	end

	wire [10:0] int_len = phy_adapt.checksum_type_setting
		? `RXACK_LEN_CRC32 : `RXACK_LEN_CRC16;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			am_lat     <= 1'b0;
			em_lat     <= 1'b0;
			ackf_lat   <= 1'b0;
			need_ack   <= 1'b0;
			seq_lat    <= 8'h00;
			pend_lat   <= 1'b0;
			rx_phy_lat <= '0;
		end
		else if (hdr_done)
		begin
			am_lat   <= ev_am;
			em_lat   <= ev_em;
			ackf_lat <= is_ack;
			need_ack <= ack_req;
			seq_lat  <= hdr.seq_num;
			pend_lat <= |pend_sel;
			rx_phy_lat <= rx_phy;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state     <= RXACK_IDLE;
			cnt       <= '0;
			ack_start <= 1'b0;
			ack_tx    <= '0;
		end
		else
		begin
			ack_start <= 1'b0;
			case (state)
			RXACK_IDLE:
				if (ev_fe && need_ack && auto_ack_enable)
				begin
					state <= RXACK_WAIT;
					cnt   <= ack_delay;
				end
			RXACK_WAIT:
				if (!auto_ack_enable)
					state <= RXACK_IDLE;
				else if (cnt == '0)
				begin
					state            <= RXACK_SEND;
					ack_start        <= 1'b1;
					ack_tx.phy       <= ack_rate_adapt_enable
						|| ack_checksum_adapt_enable
						? phy_adapt : phy_cfg;
					ack_tx.seq_num   <= seq_lat;
					ack_tx.frame_pending <= pend_lat;
					ack_tx.from_buffer <= ack_content_source;
					ack_tx.length    <= ack_content_source
						? tx_len : int_len;
				end
				else
					cnt <= cnt - 1'b1;
			RXACK_SEND:
				if (tx_done)
				begin
					state      <= RXACK_IDLE;
					ack_tx.phy <= phy_cfg;
				end
			default:
				state <= RXACK_IDLE;
			endcase
		end
	end

	// the block itself sits in prepare whenever not sending
	assign transmit_prepare_state = state != RXACK_SEND;

	// ------------------------------------------------------------
	// register file and sticky status
	// ------------------------------------------------------------
	wire [4:0] ev_vec = {ev_te, ev_fe, ev_em, ev_am, ev_fs};
	wire st_clr = wr & rd_hit_stat;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ctrl      <= '0;
			filter    <= '0;
			ack_delay <= `RXACK_DELAY_RESET;
			tx_len    <= '0;
			ack_pending_bits <= '0;
			phy_cfg   <= '0;
			status    <= '0;
			irq_pulse <= '0;
		end
		else
		begin
			irq_pulse <= ev_vec;
			if (wr && rd_hit_ctrl)
				ctrl <= pwdata[4:0];
			if (wr && rd_hit_filt)
				filter <= pwdata[4:0];
			if (wr && rd_hit_dly)
				ack_delay <= pwdata[DELAY_W-1:0];
			if (wr && rd_hit_len)
				tx_len <= pwdata[10:0];
			if (wr && rd_hit_pend)
				ack_pending_bits <= pwdata[3:0];
			if (wr && rd_hit_phy)
				phy_cfg <= pwdata[$bits(rxack_phy_t)-1:0];
			// write one to clear; a new event wins over the clear
			status[4:0] <= (status[4:0]
				& ~(st_clr ? pwdata[4:0] : 5'h00)) | ev_vec;
			status[`RXACK_ST_MATCH] <= am_lat;
			status[`RXACK_ST_EXT]   <= em_lat;
		end
	end

	always_comb
	begin
		prdata = 32'h0000_0000;
		if (rd_hit_ctrl)
			prdata[4:0] = ctrl;
		else if (rd_hit_filt)
			prdata[4:0] = filter;
		else if (rd_hit_dly)
			prdata[DELAY_W-1:0] = ack_delay;
		else if (rd_hit_len)
			prdata[10:0] = tx_len;
		else if (rd_hit_pend)
			prdata[3:0] = ack_pending_bits;
		else if (rd_hit_stat)
			prdata[6:0] = status;
		else if (rd_hit_phy)
			prdata[$bits(rxack_phy_t)-1:0] = phy_cfg;
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	fs_pulse_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		hdr_valid |=> irq_pulse[0])
		else $error("frame start not raised");
	am_gate_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		irq_pulse[1] |-> $past(filt_on))
		else $error("address match without filter");
	em_gate_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		irq_pulse[2] |-> $past(filt_on))
		else $error("extended match without filter");
	fe_cause_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		irq_pulse[3] |-> $past(frame_stored))
		else $error("frame end without stored frame");
	fe_fail_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		frame_stored && !first_level_pass |=> !irq_pulse[3])
		else $error("frame end despite failed filter");
	fe_nofilt_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		frame_stored && !filt_on
		|=> irq_pulse[3] == $past(first_level_pass))
		else $error("frame end mismatch, filter off");
	ack_nomatch_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		hdr_done && is_ack
		|=> !irq_pulse[1] && !irq_pulse[2])
		else $error("match raised for ack frame");
	ack_enable_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		ack_start
		|-> $past(state) == RXACK_WAIT && $past(auto_ack_enable))
		else $error("ack started while disabled");
	phy_restore_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		state == RXACK_SEND && tx_done
		|=> ack_tx.phy == $past(phy_cfg))
		else $error("phy settings not restored");
	te_done_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		state == RXACK_SEND && tx_done
		|=> irq_pulse[4] && state == RXACK_IDLE)
		else $error("transmit frame end missing");
	len_int_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		ack_start && !ack_tx.from_buffer |-> ack_tx.length
		== (ack_tx.phy.checksum_type_setting
		? `RXACK_LEN_CRC32 : `RXACK_LEN_CRC16))
		else $error("internal ack length wrong");
	sticky_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		status[3] && !st_clr |=> status[3])
		else $error("status flag dropped");

endmodule

// File: verification/rxack_tx_peer.sv
// transmitter stand-in: answers each ack request with a done pulse
// assumes: ack_start is a one-cycle pulse on pclk
module rxack_tx_peer
#(
	parameter int TX_CYC = 6
)
(
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic ack_start,
	output logic      tx_done
);
	timeunit 1ns;
	timeprecision 1ps;
	int cnt;
	always @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			cnt <= 0;
			tx_done <= 1'b0;
		end
		else
		begin
			tx_done <= (cnt == 1);
			if (ack_start)
				cnt <= TX_CYC;
			else if (cnt > 0)
				cnt <= cnt - 1;
		end
endmodule

// File: verification/rxack_core_tb.sv
// self-checking bench for the receive event and auto-ack block
// assumes: apb slave always ready; transmitter modelled by the peer
`include "rxack_map.svh"
module rxack_core_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import rxack_pkg::*;
	logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata;
	logic        pready, pslverr, tx_done, ack_start, tps;
	logic        hdr_valid = 0, hdr_done = 0, frame_stored = 0, flp = 0;
	rxack_hdr_t  hdr = '0;
	rxack_phy_t  rx_phy = '0;
	rxack_tx_t   ack_tx;
	logic [4:0]  irq_pulse, seen;
	logic        clr = 0;
	int          n_fail = 0, compares = 0, cyc = 0, t_fe, t_st, n_ack = 0;
	logic [31:0] q;
	logic        e;
	rxack_core #(.DELAY_W(16)) u_rxack_core (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .hdr_valid(hdr_valid), .hdr_done(hdr_done),
		.hdr(hdr), .first_level_pass(flp), .frame_stored(frame_stored),
		.rx_phy(rx_phy), .tx_done(tx_done), .ack_tx(ack_tx),
		.ack_start(ack_start), .transmit_prepare_state(tps),
		.irq_pulse(irq_pulse));
	rxack_tx_peer u_rxack_tx_peer (.pclk(pclk), .presetn(presetn),
		.ack_start(ack_start), .tx_done(tx_done));
	always #2 pclk = ~pclk;
	always @(negedge pclk)
		seen <= clr ? 5'h00 : (seen | irq_pulse);
	always @(posedge pclk)
	begin
		cyc <= cyc + 1;
		if (irq_pulse[3])
			t_fe <= cyc;
		if (ack_start)
		begin
			t_st <= cyc;
			n_ack <= n_ack + 1;
		end
		if (cyc == 20000)
		begin
			n_fail++;
			give_verdict();
		end
	end
	// ----------------------------------------------------------------
	// shared tasks
	// ----------------------------------------------------------------
	task automatic chk(input string nm, input logic [31:0] x,
		input logic [31:0] g);
		compares++;
		if (g !== x)
		begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", nm, x, g);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic frame(input rxack_hdr_t h, input logic p,
		input logic [4:0] x, input string nm);
		@(posedge pclk);
		clr <= 1'b1;
		hdr_valid <= 1'b1;
		hdr <= h;
		@(posedge pclk);
		clr <= 1'b0;
		hdr_valid <= 1'b0;
		hdr_done <= 1'b1;
		@(posedge pclk);
		hdr_done <= 1'b0;
		frame_stored <= 1'b1;
		flp <= p;
		@(posedge pclk);
		frame_stored <= 1'b0;
		repeat (3) @(posedge pclk);
		@(negedge pclk) chk(nm, {27'h0, x}, {27'h0, seen});
	endtask
	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_regs;
		apb(1'b0, `RXACK_OFF_DELAY, 32'h0);
		chk("delay reset", {16'h0, `RXACK_DELAY_RESET}, q);
		apb(1'b1, 12'h01c, 32'hffffffff);
		chk("unmapped err", 32'h1, {31'h0, e});
		apb(1'b0, 12'h01c, 32'h0);
		chk("unmapped read", 32'h0, q);
	endtask
	task automatic t_filter;
		rxack_hdr_t h;
		logic [4:0] x;
		h = '0;
		h.frame_type = `RXACK_FT_DATA;
		for (int i = 0; i < 16; i++)
		begin
			apb(1'b1, `RXACK_OFF_FILTER, {27'h0, i[2], 4'h4 & {4{i[3]}}});
			h.match_found_flag = i[0];
			h.ext_match_found_flag = i[1];
			x = 5'h01;
			x[1] = i[3] & i[0];
			x[2] = i[3] & i[1];
			x[3] = !i[3] | i[0] | i[1] | i[2];
			frame(h, 1'b1, x, "pass irqs");
			x[3] = 1'b0;
			frame(h, 1'b0, x, "fail irqs");
		end
		h.frame_type = `RXACK_FT_ACK;
		h.match_found_flag = 1'b1;
		frame(h, 1'b1, 5'h09, "ack frame irqs");
	endtask
	task automatic t_ack;
		rxack_hdr_t h;
		h = '0;
		h.frame_type = `RXACK_FT_CMD;
		h.ack_request = 1'b1;
		h.seq_num = 8'h5a;
		h.match_found_flag = 1'b1;
		h.unit_match = 4'h2;
		apb(1'b1, `RXACK_OFF_FILTER, 32'h2);
		apb(1'b1, `RXACK_OFF_PENDING, 32'h2);
		apb(1'b1, `RXACK_OFF_DELAY, 32'h5);
		apb(1'b1, `RXACK_OFF_CTRL, 32'h0);
		frame(h, 1'b1, 5'h0b, "ack off irqs");
		chk("ack when off", 32'h0, n_ack);
		apb(1'b1, `RXACK_OFF_CTRL, 32'h1);
		frame(h, 1'b1, 5'h0b, "ack irqs");
		while (ack_start !== 1'b1)
			@(negedge pclk);
		chk("ack seq", 32'h5a, {24'h0, ack_tx.seq_num});
		chk("ack pending", 32'h1, {31'h0, ack_tx.frame_pending});
		chk("ack source", 32'h0, {31'h0, ack_tx.from_buffer});
		chk("ack length", {21'h0, `RXACK_LEN_CRC16}, {21'h0, ack_tx.length});
		@(negedge pclk) chk("prepare", 32'h0, {31'h0, tps});
		chk("ack delay", 32'h6, t_st - t_fe);
		@(posedge pclk) clr <= 1'b1;
		@(posedge pclk) clr <= 1'b0;
		repeat (10) @(negedge pclk);
		chk("tx end irq", 32'h1, {31'h0, seen[4]});
		chk("prepare back", 32'h1, {31'h0, tps});
		h.frame_type = 3'h0;
		frame(h, 1'b1, 5'h0b, "beacon irqs");
		repeat (10) @(negedge pclk);
		chk("no ack count", 32'h1, n_ack);
		chk("stay prepare", 32'h1, {31'h0, tps});
	endtask
	task automatic ack_round(input rxack_hdr_t h, input rxack_phy_t x,
		input string nm);
		frame(h, 1'b1, 5'h0b, nm);
		while (ack_start !== 1'b1)
			@(negedge pclk);
		chk(nm, {22'h0, x}, {22'h0, ack_tx.phy});
		chk("buffer length", 32'h00a, {21'h0, ack_tx.length});
		chk("buffer source", 32'h1, {31'h0, ack_tx.from_buffer});
		repeat (10) @(negedge pclk);
		chk("phy restored", 32'h020, {22'h0, ack_tx.phy});
	endtask
	task automatic t_adapt;
		rxack_hdr_t h;
		h = '0;
		h.frame_type = `RXACK_FT_DATA;
		h.ack_request = 1'b1;
		h.seq_num = 8'hc3;
		h.match_found_flag = 1'b1;
		h.unit_match = 4'h2;
		apb(1'b1, `RXACK_OFF_PHYTX, 32'h020);
		apb(1'b1, `RXACK_OFF_TXLEN, 32'h00a);
		apb(1'b1, `RXACK_OFF_CTRL, 32'h00f);
		rx_phy <= rxack_phy_t'(10'h1df);
		ack_round(h, rxack_phy_t'(10'h0c0), "ofdm ack phy");
		@(posedge pclk);
		rx_phy <= rxack_phy_t'(10'h0d1);
		ack_round(h, rxack_phy_t'(10'h031), "fsk ack phy");
		apb(1'b0, `RXACK_OFF_STATUS, 32'h0);
		chk("status sticky", 32'h3f, q);
		apb(1'b1, `RXACK_OFF_STATUS, 32'h1f);
		apb(1'b0, `RXACK_OFF_STATUS, 32'h0);
		chk("status cleared", 32'h20, q);
	endtask
	task automatic give_verdict;
		$display("compares %0d n_fail %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	initial
	begin
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		t_regs();
		t_filter();
		t_ack();
		t_adapt();
		give_verdict();
	end
endmodule
